// ==== pkg/mhfi_pkg.sv ====
`default_nettype none
package mhfi_pkg;
    // Frame header codes
    localparam logic [7:0] FT_INTERNAL = 8'h01;
    localparam logic [7:0] FT_APP = 8'h05;
    localparam logic [7:0] FRAME_NUM = 8'h00;
    localparam logic [7:0] CMD_CFG_WR = 8'h01;
    localparam logic [7:0] CMD_CFG_RD = 8'h02;
    localparam logic [7:0] CMD_ROUTE_RD = 8'h03;
    localparam logic [7:0] CMD_VER_RD = 8'h06;
    localparam logic [7:0] CMD_RESET = 8'h07;
    localparam logic [7:0] CMD_NET_RD = 8'h08;
    localparam logic [7:0] CMD_APP_SEND = 8'h01;
    localparam logic [7:0] ACK_BIT = 8'h80;
    localparam int LOAD_MAX = 117;
    localparam logic [7:0] CFG_LEN = 8'h0d;
    localparam logic [7:0] CFG_FLAG = 8'ha5;
    localparam logic [7:0] RESET_ACK_LEN = 8'h01;
    localparam logic [7:0] VER_LEN = 8'h01;
    // Field limits
    localparam logic [7:0] LIFE_MAX = 8'h17;
    localparam logic [7:0] RATE_MAX = 8'h06;
    localparam logic [7:0] PARITY_MAX = 8'h02;
    localparam logic [7:0] ACK_WANTED = 8'h01;
    localparam logic [7:0] RADIUS_FIXED = 8'h07;
    // Configuration reset values
    localparam logic [23:0] RST_FREQ = 24'h6d0012;
    localparam logic [7:0] RST_POWER = 8'h07;
    localparam logic [7:0] RST_LIFE = 8'h17;
    localparam logic [15:0] RST_NET = 16'h0001;
    localparam logic [15:0] RST_NODE = 16'h0001;
    localparam logic [7:0] RST_RATE = 8'h03;
    localparam logic [7:0] RST_PARITY = 8'h00;
    // Register offsets and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FREQ = 8'h08;
    localparam logic [7:0] REG_RADIO = 8'h0c;
    localparam logic [7:0] REG_IDS = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam logic RST_CTRL_EN = 1'b1;

    typedef enum logic [1:0] {RX_HDR, RX_LOAD, RX_SUM} mhfi_rx_e;
    typedef enum logic [1:0] {K_CFG, K_VER, K_ZERO} mhfi_kind_e;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mhfi_byte_s;

    typedef struct packed {
        logic [23:0] freq;
        logic [7:0] power;
        logic [7:0] life;
        logic [15:0] network_identifier;
        logic [15:0] node_identifier;
        logic [7:0] rate;
        logic [7:0] parity;
    } mhfi_cfg_s;

    typedef struct packed {
        logic [15:0] dest;
        logic [7:0] route_type;
        logic ack_req;
    } mhfi_app_s;
endpackage : mhfi_pkg
`default_nettype wire

// ==== design/mhfi_frame_interpreter.sv ====
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module mhfi_frame_interpreter #(
    parameter logic [7:0] SRC_ROUTE_TYPE = 8'h03,
    parameter logic [7:0] VERSION_CODE = 8'h10 // Arbitrary value
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire mhfi_pkg::mhfi_byte_s rx_in,
    input wire logic tx_ready_in,
    output mhfi_pkg::mhfi_byte_s tx_out,
    output logic app_valid_out,
    output logic [7:0] app_data_out,
    output logic app_last_out,
    output mhfi_pkg::mhfi_app_s app_info_out,
    output logic reset_req_out,
    output mhfi_pkg::mhfi_cfg_s cfg_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out
);
    typedef struct packed {
        mhfi_pkg::mhfi_rx_e rx_st;
        logic [1:0] hdr_idx;
        logic [7:0] ftype;
        logic [7:0] fnum;
        logic [7:0] fcmd;
        logic [7:0] flen;
        logic [7:0] cnt;
        logic [7:0] xsum;
        logic ovf;
        logic [mhfi_pkg::LOAD_MAX-1:0][7:0] load;
        mhfi_pkg::mhfi_cfg_s cfg;
        logic tx_busy;
        mhfi_pkg::mhfi_kind_e tx_kind;
        logic [7:0] tx_type;
        logic [7:0] tx_cmd;
        logic [7:0] tx_len;
        logic [7:0] tx_idx;
        logic [7:0] tx_sum;
        mhfi_pkg::mhfi_byte_s tx;
        logic app_busy;
        logic [7:0] app_idx;
        logic [7:0] app_end;
        logic app_valid;
        logic [7:0] app_data;
        logic app_last;
        mhfi_pkg::mhfi_app_s app_info;
        logic reset_req;
        logic ctrl_en;
        logic [15:0] good_cnt;
        logic [15:0] drop_cnt;
        logic [31:0] rdata;
    } mhfi_state_s;

    mhfi_state_s st;
    mhfi_state_s next_st;

    // Load byte of an answer, config layout flag first
    function automatic logic [7:0] load_byte(input mhfi_pkg::mhfi_kind_e kind,
                                             input mhfi_pkg::mhfi_cfg_s c,
                                             input logic [7:0] j);
        logic [7:0] b;
        b = 8'h00;
        if (kind == mhfi_pkg::K_VER) begin
            b = VERSION_CODE;
        end else if (kind == mhfi_pkg::K_CFG) begin
            case (j)
                8'h00, 8'h01: b = mhfi_pkg::CFG_FLAG;
                8'h02: b = c.freq[23:16];
                8'h03: b = c.freq[15:8];
                8'h04: b = c.freq[7:0];
                8'h05: b = c.power;
                8'h06: b = c.life;
                8'h07: b = c.network_identifier[15:8];
                8'h08: b = c.network_identifier[7:0];
                8'h09: b = c.node_identifier[15:8];
                8'h0a: b = c.node_identifier[7:0];
                8'h0b: b = c.rate;
                8'h0c: b = c.parity;
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction : load_byte

    // Whole answer byte by position; checksum handled apart
    function automatic logic [7:0] frame_byte(input mhfi_state_s s, input logic [7:0] i);
        logic [7:0] b;
        case (i)
            8'h00: b = s.tx_type;
            8'h01: b = mhfi_pkg::FRAME_NUM;
            8'h02: b = s.tx_cmd;
            8'h03: b = s.tx_len;
            default: b = load_byte(s.tx_kind, s.cfg, i - 8'h04);
        endcase
        return b;
    endfunction : frame_byte

    always_comb begin
        logic [7:0] sum;
        logic frame_ok;
        logic accept;
        logic start_tx;
        logic [7:0] data_len;
        logic [7:0] data_start;
        logic [7:0] nidx;
        logic [7:0] nb;
        mhfi_pkg::mhfi_cfg_s wcfg;
        sum = 8'h00;
        frame_ok = 1'b0;
        accept = 1'b0;
        start_tx = 1'b0;
        data_len = 8'h00;
        data_start = 8'h00;
        nidx = 8'h00;
        nb = 8'h00;
        wcfg = st.cfg;
        next_st = st;
        next_st.app_valid = 1'b0;
        next_st.app_last = 1'b0;
        next_st.reset_req = 1'b0;

        // Answer byte stream; each byte held until taken
        if (st.tx_busy && st.tx.valid && tx_ready_in) begin
            if (st.tx_idx == st.tx_len + 8'h04) begin
                next_st.tx.valid = 1'b0;
                next_st.tx_busy = 1'b0;
            end else begin
                nidx = st.tx_idx + 8'h01;
                next_st.tx_idx = nidx;
                if (nidx == st.tx_len + 8'h04) begin
                    next_st.tx.data = st.tx_sum;
                end else begin
                    nb = frame_byte(st, nidx);
                    next_st.tx.data = nb;
                    next_st.tx_sum = st.tx_sum ^ nb;
                end
            end
        end

        // User data streamed out one byte per cycle
        if (st.app_busy) begin
            next_st.app_valid = 1'b1;
            next_st.app_data = st.load[st.app_idx];
            next_st.app_last = (st.app_idx + 8'h01 == st.app_end);
            next_st.app_idx = st.app_idx + 8'h01;
            if (st.app_idx + 8'h01 == st.app_end) begin
                next_st.app_busy = 1'b0;
            end
        end

        // Receive parser; load writes trail app reads, so no overlap hazard
        if (rx_in.valid && st.ctrl_en) begin
            next_st.xsum = st.xsum ^ rx_in.data;
            case (st.rx_st)
                mhfi_pkg::RX_HDR: begin
                    next_st.hdr_idx = st.hdr_idx + 2'd1;
                    case (st.hdr_idx)
                        2'd0: begin
                            next_st.ftype = rx_in.data;
                            next_st.xsum = rx_in.data;
                            next_st.ovf = 1'b0;
                        end
                        2'd1: next_st.fnum = rx_in.data;
                        2'd2: next_st.fcmd = rx_in.data;
                        default: begin
                            next_st.flen = rx_in.data;
                            next_st.cnt = 8'h00;
                            next_st.ovf = (rx_in.data > 8'(mhfi_pkg::LOAD_MAX));
                            next_st.rx_st = (rx_in.data == 8'h00) ? mhfi_pkg::RX_SUM : mhfi_pkg::RX_LOAD;
                        end
                    endcase
                end
                mhfi_pkg::RX_LOAD: begin
                    if (st.cnt < 8'(mhfi_pkg::LOAD_MAX)) begin
                        next_st.load[st.cnt[6:0]] = rx_in.data;
                    end
                    next_st.cnt = st.cnt + 8'h01;
                    if (st.cnt + 8'h01 == st.flen) begin
                        next_st.rx_st = mhfi_pkg::RX_SUM;
                    end
                end
                mhfi_pkg::RX_SUM: begin
                    sum = st.xsum ^ rx_in.data;
                    frame_ok = (sum == 8'h00) && (st.fnum == mhfi_pkg::FRAME_NUM) && !st.ovf;
                    next_st.rx_st = mhfi_pkg::RX_HDR;
                    next_st.hdr_idx = 2'd0;
                    next_st.tx_type = st.ftype;
                    next_st.tx_cmd = st.fcmd | mhfi_pkg::ACK_BIT;
                    next_st.tx_len = 8'h00;
                    next_st.tx_kind = mhfi_pkg::K_ZERO;
                    if (frame_ok && !st.tx_busy && st.ftype == mhfi_pkg::FT_INTERNAL) begin
                        case (st.fcmd)
                            mhfi_pkg::CMD_CFG_WR, mhfi_pkg::CMD_CFG_RD: begin
                                wcfg.freq = {st.load[2], st.load[3], st.load[4]};
                                wcfg.power = st.load[5];
                                wcfg.life = st.load[6];
                                wcfg.network_identifier = {st.load[7], st.load[8]};
                                wcfg.node_identifier = {st.load[9], st.load[10]};
                                wcfg.rate = st.load[11];
                                wcfg.parity = st.load[12];
                                if (st.flen == mhfi_pkg::CFG_LEN
                                    && st.load[0] == mhfi_pkg::CFG_FLAG
                                    && st.load[1] == mhfi_pkg::CFG_FLAG) begin
                                    if (st.fcmd == mhfi_pkg::CMD_CFG_RD) begin
                                        accept = 1'b1;
                                    end else if (wcfg.life <= mhfi_pkg::LIFE_MAX
                                                 && wcfg.rate <= mhfi_pkg::RATE_MAX
                                                 && wcfg.parity <= mhfi_pkg::PARITY_MAX) begin
                                        accept = 1'b1;
                                        next_st.cfg = wcfg;
                                    end
                                end
                                next_st.tx_len = mhfi_pkg::CFG_LEN;
                                next_st.tx_kind = mhfi_pkg::K_CFG;
                            end
                            mhfi_pkg::CMD_ROUTE_RD, mhfi_pkg::CMD_NET_RD: begin
                                accept = 1'b1;
                            end
                            mhfi_pkg::CMD_VER_RD: begin
                                accept = 1'b1;
                                next_st.tx_len = mhfi_pkg::VER_LEN;
                                next_st.tx_kind = mhfi_pkg::K_VER;
                            end
                            mhfi_pkg::CMD_RESET: begin
                                accept = 1'b1;
                                next_st.reset_req = 1'b1;
                                next_st.tx_len = mhfi_pkg::RESET_ACK_LEN;
                            end
                            default: accept = 1'b0;
                        endcase
                        start_tx = accept;
                    end else if (frame_ok && st.ftype == mhfi_pkg::FT_APP
                                 && st.fcmd == mhfi_pkg::CMD_APP_SEND && !st.app_busy) begin
                        // Source route adds count and two bytes per repeater
                        if (st.load[4] == SRC_ROUTE_TYPE) begin
                            data_len = st.load[7'(8'h06 + {st.load[5][6:0], 1'b0})];
                            data_start = 8'h07 + {st.load[5][6:0], 1'b0};
                        end else begin
                            data_len = st.load[5];
                            data_start = 8'h06;
                        end
                        accept = (st.load[3] == mhfi_pkg::RADIUS_FIXED)
                                 && (st.load[2] <= mhfi_pkg::ACK_WANTED)
                                 && (9'(data_start) + 9'(data_len) == 9'(st.flen))
                                 && !(st.tx_busy && st.load[2] == mhfi_pkg::ACK_WANTED);
                        if (accept) begin
                            next_st.app_info.dest = {st.load[0], st.load[1]};
                            next_st.app_info.route_type = st.load[4];
                            next_st.app_info.ack_req = st.load[2][0];
                            next_st.app_idx = data_start;
                            next_st.app_end = data_start + data_len;
                            next_st.app_busy = (data_len != 8'h00);
                            start_tx = (st.load[2] == mhfi_pkg::ACK_WANTED);
                        end
                    end
                    // Answer only when busy-free; a clash drops the frame
                    if (start_tx) begin
                        next_st.tx_busy = 1'b1;
                        next_st.tx_idx = 8'h00;
                        next_st.tx.valid = 1'b1;
                        next_st.tx.data = st.ftype;
                        next_st.tx_sum = st.ftype;
                    end
                    if (accept) begin
                        next_st.good_cnt = st.good_cnt + 16'h0001;
                    end else begin
                        next_st.drop_cnt = st.drop_cnt + 16'h0001;
                    end
                end
                default: begin
                    next_st.rx_st = mhfi_pkg::RX_HDR;
                    next_st.hdr_idx = 2'd0;
                end
            endcase
        end

        // Register port, read data one cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (reg_write_in && reg_addr_in == mhfi_pkg::REG_CTRL) begin
            next_st.ctrl_en = reg_wdata_in[mhfi_pkg::CTRL_EN_BIT];
        end
        if (reg_read_in) begin
            case (reg_addr_in)
                mhfi_pkg::REG_CTRL: next_st.rdata = {31'h0, st.ctrl_en};
                mhfi_pkg::REG_STATUS: next_st.rdata = {st.drop_cnt, st.good_cnt};
                mhfi_pkg::REG_FREQ: next_st.rdata = {8'h00, st.cfg.freq};
                mhfi_pkg::REG_RADIO: next_st.rdata = {st.cfg.power, st.cfg.life, st.cfg.rate, st.cfg.parity};
                mhfi_pkg::REG_IDS: next_st.rdata = {st.cfg.network_identifier, st.cfg.node_identifier};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '0;
            st.rx_st <= mhfi_pkg::RX_HDR;
            st.tx_kind <= mhfi_pkg::K_ZERO;
            st.ctrl_en <= mhfi_pkg::RST_CTRL_EN;
            st.cfg.freq <= mhfi_pkg::RST_FREQ;
            st.cfg.power <= mhfi_pkg::RST_POWER;
            st.cfg.life <= mhfi_pkg::RST_LIFE;
            st.cfg.network_identifier <= mhfi_pkg::RST_NET;
            st.cfg.node_identifier <= mhfi_pkg::RST_NODE;
            st.cfg.rate <= mhfi_pkg::RST_RATE;
            st.cfg.parity <= mhfi_pkg::RST_PARITY;
        end else begin
            st <= next_st;
        end
    end

    assign tx_out = st.tx;
    assign app_valid_out = st.app_valid;
    assign app_data_out = st.app_data;
    assign app_last_out = st.app_last;
    assign app_info_out = st.app_info;
    assign reset_req_out = st.reset_req;
    assign cfg_out = st.cfg;
    assign reg_rdata_out = st.rdata;
endmodule : mhfi_frame_interpreter
`default_nettype wire

// ==== tb/mhfi_frame_interpreter_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module mhfi_frame_interpreter_properties (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic tx_ready_in,
    input wire mhfi_pkg::mhfi_byte_s tx_out,
    input wire logic app_valid_out,
    input wire logic app_last_out,
    input wire logic reset_req_out,
    input wire mhfi_pkg::mhfi_cfg_s cfg_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [31:0] reg_rdata_out
);
    logic [7:0] idx;
    logic [7:0] len;
    logic [7:0] acc;
    logic take;
    assign take = tx_out.valid && tx_ready_in;
    // Tracks answer framing so the checksum byte is found from the length byte
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idx <= 8'h00;
            len <= 8'h00;
            acc <= 8'h00;
        end else if (take) begin
            if (idx == 8'h03) len <= tx_out.data;
            if (idx > 8'h03 && idx == len + 8'h04) begin
                idx <= 8'h00;
                acc <= 8'h00;
            end else begin
                idx <= idx + 8'h01;
                acc <= acc ^ tx_out.data;
            end
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    chk_tx_hold: assert property (tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out.data))
        else $error("tx byte changed before taken");
    chk_tx_type: assert property (take && idx == 8'h00 |-> tx_out.data inside {8'h01, 8'h05})
        else $error("bad answer frame type");
    chk_tx_number: assert property (take && idx == 8'h01 |-> tx_out.data == 8'h00)
        else $error("answer frame number not zero");
    chk_tx_ackcode: assert property (take && idx == 8'h02 |-> tx_out.data[7])
        else $error("answer command lacks ack bit");
    chk_tx_length: assert property (take && idx == 8'h03 |-> tx_out.data <= 8'd117)
        else $error("answer load too long");
    chk_tx_sum: assert property (take && idx > 8'h03 && idx == len + 8'h04 |-> tx_out.data == acc)
        else $error("answer checksum wrong");
    chk_reset_pulse: assert property (reset_req_out |=> !reset_req_out)
        else $error("reset request longer than one cycle");
    chk_app_last: assert property (app_last_out |-> app_valid_out)
        else $error("last flag without data byte");
    chk_freq_read: assert property ($past(reg_read_in) && $past(reg_addr_in) == 8'h08
        |-> reg_rdata_out[23:0] == $past(cfg_out.freq))
        else $error("frequency read mismatch");
    chk_cfg_codes: assert property (cfg_out.life <= 8'h17 && cfg_out.rate <= 8'h06 && cfg_out.parity <= 8'h02)
        else $error("configuration code out of range");
endmodule : mhfi_frame_interpreter_properties
`default_nettype wire

// ==== tb/mhfi_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mhfi_host_model (
    input wire logic clk_sys_in,
    input wire mhfi_pkg::mhfi_byte_s tx_in,
    output mhfi_pkg::mhfi_byte_s rx_out,
    output logic tx_ready_out
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    initial begin
        rx_out = '0;
        tx_ready_out = 1'b1;
    end
    // Slow mode stalls every other cycle so answer bytes must hold
    always @(posedge clk_sys_in) begin
        if (tx_in.valid === 1'b1 && tx_ready_out) got.push_back(tx_in.data);
        tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    end
    task automatic send(input logic [7:0] f[$], input int gap);
        foreach (f[i]) begin
            @(posedge clk_sys_in);
            rx_out <= '{valid: 1'b1, data: f[i]};
            @(posedge clk_sys_in);
            rx_out <= '{valid: 1'b0, data: ~f[i]};
            repeat (gap) @(posedge clk_sys_in);
        end
    endtask : send
endmodule : mhfi_host_model
`default_nettype wire

// ==== tb/tb_mhfi_frame_interpreter.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_mhfi_frame_interpreter;
    typedef logic [7:0] mhfi_bq_t[$];
    localparam logic [7:0] VER = 8'h10; // Arbitrary value
    localparam logic [7:0] BAD_POS [4] = '{8'd0, 8'd6, 8'd11, 8'd12};
    localparam logic [7:0] BAD_VAL [4] = '{8'ha4, 8'h18, 8'h07, 8'h03};
    localparam logic [7:0] CMDS [4] = '{8'h03, 8'h06, 8'h07, 8'h08};
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    mhfi_pkg::mhfi_byte_s rx_in, tx_out;
    logic tx_ready_in, app_valid_out, app_last_out, reset_req_out;
    logic [7:0] app_data_out, c;
    mhfi_pkg::mhfi_app_s app_info_out;
    mhfi_pkg::mhfi_cfg_s cfg_out, exp_cfg;
    logic [31:0] reg_rdata_out, rd;
    logic [15:0] lfsr = 16'h44d0;
    int n_mismatch = 0, n_tests = 0, n_ok = 0, n_drop = 0, n_rst = 0, last_at = 0, n;
    mhfi_bq_t app_q, f, e, d, none;
    always #4 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        if (app_valid_out === 1'b1) app_q.push_back(app_data_out);
        if (app_last_out === 1'b1) last_at = app_q.size();
        if (reset_req_out === 1'b1) n_rst++;
    end
    mhfi_frame_interpreter #(.SRC_ROUTE_TYPE(8'h03), .VERSION_CODE(VER)) dut (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .rx_in(rx_in), .tx_ready_in(tx_ready_in), .tx_out(tx_out),
        .app_valid_out(app_valid_out), .app_data_out(app_data_out), .app_last_out(app_last_out),
        .app_info_out(app_info_out), .reset_req_out(reset_req_out), .cfg_out(cfg_out),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out));
    mhfi_host_model u_host (.clk_sys_in(clk_sys_in), .tx_in(tx_out), .rx_out(rx_in), .tx_ready_out(tx_ready_in));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    function automatic mhfi_bq_t frame(logic [7:0] t, logic [7:0] cmd, mhfi_bq_t ld, logic [7:0] num = 8'h00);
        mhfi_bq_t q;
        logic [7:0] s;
        q = {t, num, cmd, 8'(ld.size())};
        q = {q, ld};
        s = 8'h00;
        foreach (q[i]) s ^= q[i];
        q.push_back(s);
        return q;
    endfunction : frame
    function automatic mhfi_bq_t cfg_load(mhfi_pkg::mhfi_cfg_s k);
        return {8'ha5, 8'ha5, k.freq[23:16], k.freq[15:8], k.freq[7:0], k.power, k.life,
            k.network_identifier[15:8], k.network_identifier[7:0], k.node_identifier[15:8],
            k.node_identifier[7:0], k.rate, k.parity};
    endfunction : cfg_load
    task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // Kind 1 counts as accepted, 0 as dropped, 2 as ignored
    task automatic xfer(input mhfi_bq_t req, input mhfi_bq_t exp, input int kind);
        int k;
        u_host.got.delete();
        u_host.send(req, rnd() % 3);
        k = 0;
        while (u_host.got.size() < exp.size() && k < 400) begin
            @(posedge clk_sys_in);
            k++;
        end
        repeat (16) @(posedge clk_sys_in);
        check(u_host.got.size(), exp.size(), "answer length");
        foreach (exp[i]) check(u_host.got[i], exp[i], "answer byte");
        n_ok += int'(kind == 1);
        n_drop += int'(kind == 0);
    endtask : xfer
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
    endtask : reg_wr
    task automatic check_regs();
        reg_rd(mhfi_pkg::REG_FREQ, rd);
        check(rd, {8'h00, exp_cfg.freq}, "freq reg");
        reg_rd(mhfi_pkg::REG_RADIO, rd);
        check(rd, {exp_cfg.power, exp_cfg.life, exp_cfg.rate, exp_cfg.parity}, "radio reg");
        reg_rd(mhfi_pkg::REG_IDS, rd);
        check(rd, {exp_cfg.network_identifier, exp_cfg.node_identifier}, "id reg");
        reg_rd(mhfi_pkg::REG_STATUS, rd);
        check(rd, {16'(n_drop), 16'(n_ok)}, "status reg");
        reg_rd(8'h20, rd);
        check(rd, 32'h0, "unmapped reg");
        check(cfg_out, exp_cfg, "cfg port");
    endtask : check_regs
    initial begin
        #(8 * 60000);
        n_mismatch++;
        complete_run();
    end
    initial begin
        exp_cfg = '{mhfi_pkg::RST_FREQ, mhfi_pkg::RST_POWER, mhfi_pkg::RST_LIFE, mhfi_pkg::RST_NET,
            mhfi_pkg::RST_NODE, mhfi_pkg::RST_RATE, mhfi_pkg::RST_PARITY};
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        reg_rd(mhfi_pkg::REG_CTRL, rd);
        check(rd[0], 1'b1, "enable at reset");
        check_regs();
        u_host.slow = 1'b1;
        xfer(frame(8'h01, 8'h02, cfg_load('0)), frame(8'h01, 8'h82, cfg_load(exp_cfg)), 1);
        check(u_host.got[17], 8'he2, "read answer sum");
        u_host.slow = 1'b0;
        for (int i = 0; i < 3; i++) begin
            exp_cfg = '{{rnd(), rnd(), rnd()}, rnd() % 8, rnd() % 24, {rnd(), rnd()}, {rnd(), rnd()},
                rnd() % 7, rnd() % 3};
            if (i == 2) exp_cfg = '{24'hffffff, 8'h07, 8'h17, 16'hffff, 16'hffff, 8'h06, 8'h02};
            xfer(frame(8'h01, 8'h01, cfg_load(exp_cfg)), frame(8'h01, 8'h81, cfg_load(exp_cfg)), 1);
            check_regs();
        end
        for (int i = 0; i < 4; i++) begin
            c = CMDS[i];
            e.delete();
            if (c == 8'h06) e.push_back(VER);
            if (c == 8'h07) e.push_back(8'h00);
            xfer(frame(8'h01, c, none), frame(8'h01, c | 8'h80, e), 1);
        end
        check(n_rst, 1, "reset pulses");
        f = frame(8'h01, 8'h02, cfg_load('0));
        f[16] ^= 8'h01;
        xfer(f, none, 0);
        xfer(frame(8'h01, 8'h06, none, 8'h01), none, 0);
        xfer(frame(8'h01, 8'h04, none), none, 0);
        xfer(frame(8'h02, 8'h06, none), none, 0);
        for (int i = 0; i < 4; i++) begin
            f = cfg_load(exp_cfg);
            f[BAD_POS[i]] = BAD_VAL[i];
            xfer(frame(8'h01, 8'h01, f), none, 0);
        end
        reg_wr(mhfi_pkg::REG_CTRL, 32'h0);
        xfer(frame(8'h01, 8'h06, none), none, 2);
        reg_wr(mhfi_pkg::REG_CTRL, 32'h1);
        check_regs();
        for (int j = 0; j < 3; j++) begin
            n = 1 + rnd() % 8;
            f = {8'h00, 8'h02, 8'(j == 1), 8'h07, (j == 2) ? 8'h03 : 8'h01};
            if (j == 2) f = {f, 8'h01, 8'h00, 8'h05};
            f.push_back(8'(n));
            d.delete();
            repeat (n) d.push_back(rnd());
            f = {f, d};
            app_q.delete();
            last_at = 0;
            e = none;
            if (j == 1) e = frame(8'h05, 8'h81, none);
            xfer(frame(8'h05, 8'h01, f), e, 1);
            check(app_q.size(), n, "app length");
            foreach (d[i]) check(app_q[i], d[i], "app byte");
            check(last_at, n, "app last");
            check(app_info_out, {16'h0002, f[4], 1'(j == 1)}, "app info");
        end
        f[3] = 8'h06;
        xfer(frame(8'h05, 8'h01, f), none, 0);
        check_regs();
        complete_run();
    end
endmodule : tb_mhfi_frame_interpreter
bind mhfi_frame_interpreter mhfi_frame_interpreter_properties u_props (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .tx_ready_in(tx_ready_in), .tx_out(tx_out), .app_valid_out(app_valid_out),
    .app_last_out(app_last_out), .reset_req_out(reset_req_out), .cfg_out(cfg_out),
    .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out));
`default_nettype wire
